// [hw/dma_seq_consts.vh]
// Purpose: Constants for the converter-to-data-memory sequencer
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Offsets are byte addresses; bits above each field read zero
`ifndef DMA_SEQ_CONSTS_VH
`define DMA_SEQ_CONSTS_VH

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_CONFIG      12'h004
`define OFS_INSTR_PTR   12'h008
`define OFS_INSTR_DATA  12'h00C
`define OFS_DEST_START  12'h010
`define OFS_DEST_PTR    12'h014
`define OFS_CUR_INSTR   12'h018
`define OFS_START_BND   12'h01C
`define OFS_REP_LIMIT   12'h020
`define OFS_REP_COUNT   12'h024

// Control register fields
`define CTRL_EN_BIT     7
`define CTRL_DONE_BIT   6
`define CTRL_ERR_B_BIT  4
`define CTRL_ERR_A_BIT  3
`define CTRL_WARN_B_BIT 1
`define CTRL_WARN_A_BIT 0

// Configuration register fields
`define CFG_HOLD_BIT    4
`define CFG_BUSY_BIT    5

// Instruction fields
`define INS_CONT_BIT    7
`define INS_DIFF_BIT    6
`define INS_B_BIT       5
`define INS_A_BIT       4

// Reset values
`define RST_CFG         1'b0
`define RST_WORD16      16'h0000

`endif

// [hw/instr_store.v]
// Purpose: Instruction store, one write port and two read ports
// Assumes: Synchronous write, combinational reads
// Notes:   Depth and width are parameters
`timescale 1ns/1ps
module instr_store #(
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter DW    = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr_sw,
  output wire [DW-1:0] rdata_sw,
  input  wire [AW-1:0] raddr_seq,
  output wire [DW-1:0] rdata_seq
);
  // No reset: contents are defined only once software loads them
  reg [DW-1:0] mem [0:DEPTH-1];

  // Single write port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Software and sequencer read independently
  assign rdata_sw  = mem[raddr_sw];
  assign rdata_seq = mem[raddr_seq];
endmodule

// [hw/result_hold.v]
// Purpose: Per-converter holding buffer with overflow detection
// Assumes: done is a one-cycle pulse per finished conversion
// Notes:   Warning on result while buffer full; error on a second one
`timescale 1ns/1ps
`include "dma_seq_consts.vh"
module result_hold #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         done,
  input  wire [W-1:0] result,
  input  wire         want,
  input  wire         take,
  output reg  [W-1:0] data_reg,
  output reg          full_reg,
  output wire         warn,
  output wire         err
);
  // Result waiting in the converter register behind a full buffer
  reg         pend_reg;
  reg [W-1:0] pend_data_reg;

  // Warning: result lands while buffer still unwritten
  assign warn = done & want & full_reg & ~take;
  // Error: one more arrives while the previous one still waits
  assign err  = done & want & pend_reg & ~take;

  // Buffer fill, drain, and pending overwrite
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg      <= `RST_WORD16;
      full_reg      <= 1'b0;
      pend_reg      <= 1'b0;
      pend_data_reg <= `RST_WORD16;
    end else if (done & want & (~full_reg | take) & ~pend_reg) begin
      data_reg <= result;
      full_reg <= 1'b1;
    end else if (done & want) begin
      pend_reg      <= 1'b1;
      pend_data_reg <= result; // R25
      if (take) begin
        data_reg <= pend_data_reg;
        pend_reg <= 1'b1;
      end
    end else if (take) begin
      data_reg <= pend_data_reg;
      full_reg <= pend_reg;
      pend_reg <= 1'b0;
    end
  end
endmodule

// [hw/dma_seq.v]
// Purpose: Sequencer moving converter results into data memory
// Assumes: Memory write ports are single-cycle; inputs synchronous to CLK
// Notes:   Mode 0 only; registers on APB
// Function
// R01 - Instruction store holds 64 entries of 8 bits.
// R02 - Data port writes or reads the store at the pointer.
// R03 - Pointer advances after every data port read or write.
// R04 - Instructions only pick results to await; no conversion started here.
// R05 - 0x00 ends operation; 0x80 ends with continuous run; no data written.
// R06 - Codes select first, second or both; first written before second.
// R07 - Differential codes take the first result word, optionally then second.
// R08 - Each data instruction writes exactly 2 or 4 bytes.
// R09 - On-chip writes only in cycles the core leaves memory free.
// R10 - Hold bit low gives off-chip memory to sequencer, high to core.
// R11 - While hold low, core off-chip accesses complete with no effect.
// R12 - Off-chip writes wait until the hold bit is low.
// R13 - Result arriving before previous is written signals overflow.
// R14 - Software checks busy before setting hold, and clears hold afterwards.
// R15 - Enable loads destination pointer from destination start.
// R16 - Destination pointer grows by 2 per word, 4 per pair.
// R17 - Operation start loads current address from start boundary, then fetches.
// R18 - Mode 0 runs each instruction once then advances.
// R19 - End-of-operation reloads current address from start boundary.
// R20 - Continuous-run end ignores the repeat counter and keeps running.
// R21 - Otherwise each end decrements counter; run continues until zero.
// R22 - Operation start loads repeat counter from repeat limit.
// R23 - Sticky operations-complete flag sets when idle; software clears.
// R24 - Result arriving at a full holding buffer sets warning flag.
// R25 - Second early result overwrites and sets the error flag.
// R26 - Non-continuous run ending at zero stops fetching and goes idle.
`timescale 1ns/1ps
`include "dma_seq_consts.vh"
module dma_seq #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        CONV_A_DONE,
  input  wire [15:0] CONV_A_RESULT,
  input  wire        CONV_B_DONE,
  input  wire [15:0] CONV_B_RESULT,
  input  wire        CORE_ONCHIP_BUSY,
  input  wire        CORE_XM_REQ,
  input  wire        CORE_XM_WE,
  input  wire [15:0] CORE_XM_ADDR,
  input  wire [15:0] CORE_XM_WDATA,
  output reg  [15:0] CORE_XM_RDATA,
  output reg         ONCHIP_WE,
  output reg  [15:0] ONCHIP_ADDR,
  output reg  [15:0] ONCHIP_WDATA,
  output reg         XM_WE,
  output reg         XM_RE,
  output reg  [15:0] XM_ADDR,
  output reg  [15:0] XM_WDATA,
  input  wire [15:0] XM_RDATA,
  output reg         SEQ_ACTIVE
);
  // Sequencer states
  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_WAIT  = 2'd2;
  localparam ST_WRITE = 2'd3;

  // Destination range at and above this address is off-chip
  localparam [15:0] OFFCHIP_BASE = 16'h1000;

  reg [1:0]    state_reg;
  reg          enable_reg;
  reg          done_reg;
  reg          warn_a_reg;
  reg          warn_b_reg;
  reg          err_a_reg;
  reg          err_b_reg;
  reg          hold_reg;
  reg [AW-1:0] iptr_reg;
  reg [15:0]   dest_start_reg;
  reg [15:0]   dest_ptr_reg;
  reg [AW-1:0] cur_reg;
  reg [AW-1:0] bnd_reg;
  reg [15:0]   limit_reg;
  reg [15:0]   count_reg;
  reg [7:0]    instr_reg;
  reg          second_reg;
  reg          xm_wr_reg;

  wire         acc      = PSEL & PENABLE & PREADY;
  wire         wr       = acc & PWRITE;
  wire [7:0]   sw_rdata;
  wire [7:0]   seq_rdata;
  wire         store_we = wr & (PADDR == `OFS_INSTR_DATA); // R02

  // Decode which results an instruction asks for
  function want_first;
    input [7:0] ins;
    begin
      want_first = ins[`INS_A_BIT] | ins[`INS_DIFF_BIT]; // R06 R07
    end
  endfunction

  function want_second;
    input [7:0] ins;
    begin
      want_second = ins[`INS_B_BIT];
    end
  endfunction

  function is_end;
    input [7:0] ins;
    begin
      is_end = (ins[6:0] == 7'h00); // R05
    end
  endfunction

  // Instruction store
  instr_store #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .DW    (8)
  ) u_store (
    .clk       (CLK),
    .we        (store_we),
    .waddr     (iptr_reg),
    .wdata     (PWDATA[7:0]),
    .raddr_sw  (iptr_reg),
    .rdata_sw  (sw_rdata),
    .raddr_seq (cur_reg),
    .rdata_seq (seq_rdata)
  ); // R01

  // Holding buffers; results only awaited, never requested
  wire        run     = (state_reg != ST_IDLE);
  wire        finish  = (state_reg == ST_FETCH) & is_end(seq_rdata) &
                        ~seq_rdata[`INS_CONT_BIT] & (count_reg <= 16'h0001);
  wire        want_a  = run & want_first(instr_reg); // R04
  wire        want_b  = run & want_second(instr_reg);
  wire [15:0] a_data;
  wire [15:0] b_data;
  wire        a_full;
  wire        b_full;
  wire        a_warn;
  wire        b_warn;
  wire        a_err;
  wire        b_err;

  // Memory side: on-chip waits for core idle, off-chip for hold low
  wire        to_xm    = (dest_ptr_reg >= OFFCHIP_BASE);
  wire        path_ok  = to_xm ? ~hold_reg : ~CORE_ONCHIP_BUSY; // R09 R10 R12
  wire        use_a    = want_a & ~second_reg;
  wire        src_full = use_a ? a_full : b_full;
  wire        do_write = (state_reg == ST_WRITE) & src_full & path_ok;
  wire        take_a   = do_write & use_a;
  wire        take_b   = do_write & ~use_a;
  wire        last_wd  = ~(use_a & want_b);

  result_hold #(.W(16)) u_hold_a (
    .clk      (CLK),
    .rst_n    (RST_N),
    .done     (CONV_A_DONE),
    .result   (CONV_A_RESULT),
    .want     (want_a),
    .take     (take_a),
    .data_reg (a_data),
    .full_reg (a_full),
    .warn     (a_warn),
    .err      (a_err)
  );

  result_hold #(.W(16)) u_hold_b (
    .clk      (CLK),
    .rst_n    (RST_N),
    .done     (CONV_B_DONE),
    .result   (CONV_B_RESULT),
    .want     (want_b),
    .take     (take_b),
    .data_reg (b_data),
    .full_reg (b_full),
    .warn     (b_warn),
    .err      (b_err)
  );

  // Sequencer, pointers and counters
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg    <= ST_IDLE;
      dest_ptr_reg <= `RST_WORD16;
      cur_reg      <= {AW{1'b0}};
      count_reg    <= `RST_WORD16;
      instr_reg    <= 8'h00;
      second_reg   <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      if (wr & (PADDR == `OFS_CTRL) & ~PWDATA[`CTRL_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (enable_reg) begin
            dest_ptr_reg <= dest_start_reg; // R15
            cur_reg      <= bnd_reg; // R17
            count_reg    <= limit_reg; // R22
            state_reg    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          instr_reg  <= seq_rdata; // R17
          second_reg <= 1'b0;
          if (is_end(seq_rdata)) begin
            cur_reg <= bnd_reg; // R19
            if (seq_rdata[`INS_CONT_BIT]) begin
              state_reg <= ST_FETCH; // R20
            end else if ((count_reg == 16'h0000) || (count_reg == 16'h0001)) begin
              count_reg <= 16'h0000;
              state_reg <= ST_IDLE; // R26
              done_reg  <= 1'b1; // R23
            end else begin
              count_reg <= count_reg - 16'h0001; // R21
            end
          end else begin
            state_reg <= ST_WRITE;
          end
        end
        ST_WAIT: begin
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          if (do_write) begin
            dest_ptr_reg <= dest_ptr_reg + 16'h0002; // R08 R16
            if (last_wd) begin
              cur_reg   <= cur_reg + {{(AW-1){1'b0}}, 1'b1}; // R18
              state_reg <= ST_FETCH;
            end else begin
              second_reg <= 1'b1; // R06
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Stop request from software ends the run at once
      if (~enable_reg & run) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // Memory write ports, registered straight from the write decision
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ONCHIP_WE    <= 1'b0;
      ONCHIP_ADDR  <= `RST_WORD16;
      ONCHIP_WDATA <= `RST_WORD16;
      xm_wr_reg    <= 1'b0;
      XM_ADDR      <= `RST_WORD16;
      XM_WDATA     <= `RST_WORD16;
    end else begin
      ONCHIP_WE <= do_write & ~to_xm;
      xm_wr_reg <= do_write & to_xm;
      if (do_write) begin
        ONCHIP_ADDR  <= dest_ptr_reg;
        ONCHIP_WDATA <= use_a ? a_data : b_data;
        XM_ADDR      <= dest_ptr_reg;
        XM_WDATA     <= use_a ? a_data : b_data;
      end else if (hold_reg) begin
        XM_ADDR  <= CORE_XM_ADDR; // R10
        XM_WDATA <= CORE_XM_WDATA;
      end
    end
  end

  // Off-chip strobes: core is cut off while the sequencer owns the bus
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      XM_WE         <= 1'b0;
      XM_RE         <= 1'b0;
      CORE_XM_RDATA <= `RST_WORD16;
      SEQ_ACTIVE    <= 1'b0;
    end else begin
      XM_WE         <= (do_write & to_xm) | (hold_reg & CORE_XM_REQ & CORE_XM_WE); // R11
      XM_RE         <= hold_reg & CORE_XM_REQ & ~CORE_XM_WE; // R11
      CORE_XM_RDATA <= hold_reg ? (XM_RE ? XM_RDATA : CORE_XM_RDATA) : 16'h0000; // R11
      SEQ_ACTIVE    <= run;
    end
  end

  // Software registers; hardware sets win over software clears
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_reg     <= 1'b0;
      warn_a_reg     <= 1'b0;
      warn_b_reg     <= 1'b0;
      err_a_reg      <= 1'b0;
      err_b_reg      <= 1'b0;
      hold_reg       <= `RST_CFG;
      iptr_reg       <= {AW{1'b0}};
      dest_start_reg <= `RST_WORD16;
      bnd_reg        <= {AW{1'b0}};
      limit_reg      <= `RST_WORD16;
    end else begin
      if (wr) begin
        case (PADDR)
          `OFS_CTRL: begin
            enable_reg <= PWDATA[`CTRL_EN_BIT];
            warn_a_reg <= warn_a_reg & PWDATA[`CTRL_WARN_A_BIT];
            warn_b_reg <= warn_b_reg & PWDATA[`CTRL_WARN_B_BIT];
            err_a_reg  <= err_a_reg & PWDATA[`CTRL_ERR_A_BIT];
            err_b_reg  <= err_b_reg & PWDATA[`CTRL_ERR_B_BIT];
          end
          `OFS_CONFIG:     hold_reg       <= PWDATA[`CFG_HOLD_BIT]; // R14
          `OFS_INSTR_PTR:  iptr_reg       <= PWDATA[AW-1:0];
          `OFS_DEST_START: dest_start_reg <= PWDATA[15:0];
          `OFS_START_BND:  bnd_reg        <= PWDATA[AW-1:0];
          `OFS_REP_LIMIT:  limit_reg      <= PWDATA[15:0];
          default: ;
        endcase
      end
      if (acc & (PADDR == `OFS_INSTR_DATA)) begin
        iptr_reg <= iptr_reg + {{(AW-1){1'b0}}, 1'b1}; // R03
      end
      if (finish) enable_reg <= 1'b0; // R26
      if (a_warn) warn_a_reg <= 1'b1; // R13 R24
      if (b_warn) warn_b_reg <= 1'b1; // R24
      if (a_err) err_a_reg <= 1'b1; // R13 R25
      if (b_err) err_b_reg <= 1'b1; // R25
    end
  end

  // APB answer one cycle after setup; offsets above the last register give PSLVERR
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & (PADDR > `OFS_REP_COUNT);
      PRDATA  <= 32'h00000000;
      if (PSEL & ~PENABLE & ~PWRITE) begin
        case (PADDR)
          `OFS_CTRL: PRDATA <= {24'h000000, run, done_reg, 1'b0, err_b_reg, err_a_reg,
                                1'b0, warn_b_reg, warn_a_reg};
          `OFS_CONFIG:     PRDATA <= {26'h0, xm_wr_reg, hold_reg, 4'h0};
          `OFS_INSTR_PTR:  PRDATA <= {{(32-AW){1'b0}}, iptr_reg};
          `OFS_INSTR_DATA: PRDATA <= {24'h000000, sw_rdata}; // R02
          `OFS_DEST_START: PRDATA <= {16'h0000, dest_start_reg};
          `OFS_DEST_PTR:   PRDATA <= {16'h0000, dest_ptr_reg};
          `OFS_CUR_INSTR:  PRDATA <= {{(32-AW){1'b0}}, cur_reg};
          `OFS_START_BND:  PRDATA <= {{(32-AW){1'b0}}, bnd_reg};
          `OFS_REP_LIMIT:  PRDATA <= {16'h0000, limit_reg};
          `OFS_REP_COUNT:  PRDATA <= {16'h0000, count_reg};
          default:         PRDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// [test/far_side.sv]
// Purpose: Converter pair and off-chip data memory beside the sequencer
// Assumes: The bench decides when each conversion finishes
// Notes:   Read lines carry a moving pattern outside read cycles; result lines hold a fixed snapshot of it
`timescale 1ns/1ps
module far_side (
  input  wire         CLK,
  input  wire         XM_WE,
  input  wire         XM_RE,
  input  wire  [15:0] XM_ADDR,
  input  wire  [15:0] XM_WDATA,
  output wire  [15:0] XM_RDATA,
  output logic        CONV_A_DONE,
  output logic        CONV_B_DONE,
  output logic [15:0] CONV_A_RESULT,
  output logic [15:0] CONV_B_RESULT
);
  logic [15:0] mem [0:255];
  logic [15:0] junk = 16'h5A3C;

  initial begin
    CONV_A_DONE = 1'b0;
    CONV_B_DONE = 1'b0;
    CONV_A_RESULT = 16'h0000;
    CONV_B_RESULT = 16'h0000;
  end

  // Memory drives data only under a read strobe, so stale data cannot pass
  assign XM_RDATA = XM_RE ? mem[XM_ADDR[7:0]] : junk;

  // Store writes; keep the idle pattern moving every cycle
  always @(posedge CLK) begin
    junk <= {junk[14:0], ~junk[15]};
    if (XM_WE) begin
      mem[XM_ADDR[7:0]] <= XM_WDATA;
    end
  end

  // Conversions start on their own trigger; results hold for one cycle only
  task automatic convert(input logic a, input logic b, input logic [15:0] v);
    @(posedge CLK);
    CONV_A_DONE <= a;
    CONV_B_DONE <= b;
    CONV_A_RESULT <= v;
    CONV_B_RESULT <= ~v;
    @(posedge CLK);
    CONV_A_DONE <= 1'b0;
    CONV_B_DONE <= 1'b0;
    CONV_A_RESULT <= junk;
    CONV_B_RESULT <= ~junk;
  endtask
endmodule

// [test/dma_seq_sva.sv]
// Purpose: Port-level checks for the sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Checks what the design drives against its APB and core inputs
`timescale 1ns/1ps
module dma_seq_sva (
  input wire        CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        CORE_ONCHIP_BUSY,
  input wire        CORE_XM_REQ,
  input wire        CORE_XM_WE,
  input wire        ONCHIP_WE,
  input wire [15:0] ONCHIP_ADDR,
  input wire        XM_WE,
  input wire        XM_RE,
  input wire        SEQ_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  logic [15:0] last_reg;
  logic        seen_reg;

  // Last word address of this run; cleared when idle since enable reloads it
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_reg <= 16'h0000;
      seen_reg <= 1'b0;
    end else if (ONCHIP_WE) begin
      last_reg <= ONCHIP_ADDR;
      seen_reg <= 1'b1;
    end else if (!SEQ_ACTIVE) begin
      seen_reg <= 1'b0;
    end
  end

  a_apb_answer: assert property (setup_s |=> PREADY) else $error("no ready after setup");
  a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_onchip_free: assert property (ONCHIP_WE |-> !$past(CORE_ONCHIP_BUSY))
    else $error("on-chip write while core busy");
  a_dest_step: assert property (ONCHIP_WE && seen_reg |->
    ONCHIP_ADDR == last_reg + 16'h0002) else $error("destination step wrong");
  a_write_run: assert property (ONCHIP_WE |-> SEQ_ACTIVE || $past(SEQ_ACTIVE))
    else $error("write while idle");
  a_xm_read_cause: assert property (XM_RE |-> $past(CORE_XM_REQ && !CORE_XM_WE))
    else $error("off-chip read without core request");
  a_core_wr_cause: assert property (XM_WE && !SEQ_ACTIVE && !$past(SEQ_ACTIVE)
    |-> $past(CORE_XM_REQ && CORE_XM_WE)) else $error("off-chip write without cause");
endmodule

bind dma_seq dma_seq_sva u_sva (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_ONCHIP_BUSY(CORE_ONCHIP_BUSY),
  .CORE_XM_REQ(CORE_XM_REQ), .CORE_XM_WE(CORE_XM_WE), .ONCHIP_WE(ONCHIP_WE),
  .ONCHIP_ADDR(ONCHIP_ADDR), .XM_WE(XM_WE), .XM_RE(XM_RE), .SEQ_ACTIVE(SEQ_ACTIVE));

// [test/dma_seq_tb.sv]
// Purpose: Self-checking bench for the sequencer
// Assumes: Bench waits for PREADY and never counts on an APB latency
// Notes:   Monitors log every memory write for comparison
`timescale 1ns/1ps
`include "dma_seq_consts.vh"
module dma_seq_tb;
  logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, perr;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA;
  logic        PREADY, PSLVERR, CONV_A_DONE, CONV_B_DONE, CORE_ONCHIP_BUSY = 0;
  logic        CORE_XM_REQ = 0, CORE_XM_WE = 0, ONCHIP_WE, XM_WE, XM_RE, SEQ_ACTIVE;
  logic [15:0] CONV_A_RESULT, CONV_B_RESULT, CORE_XM_ADDR = 0, CORE_XM_WDATA = 0;
  logic [15:0] CORE_XM_RDATA, ONCHIP_ADDR, ONCHIP_WDATA, XM_ADDR, XM_WDATA, XM_RDATA;
  logic [31:0] wq[$], xq[$], ea[$];
  logic [7:0]  prog [6] = '{8'h90, 8'h20, 8'hB0, 8'hD0, 8'h70, 8'h00};
  int          num_errors = 0, n_tests = 0, n_re = 0;

  dma_seq u_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_A_DONE(CONV_A_DONE), .CONV_A_RESULT(CONV_A_RESULT), .CONV_B_DONE(CONV_B_DONE),
    .CONV_B_RESULT(CONV_B_RESULT), .CORE_ONCHIP_BUSY(CORE_ONCHIP_BUSY),
    .CORE_XM_REQ(CORE_XM_REQ), .CORE_XM_WE(CORE_XM_WE), .CORE_XM_ADDR(CORE_XM_ADDR),
    .CORE_XM_WDATA(CORE_XM_WDATA), .CORE_XM_RDATA(CORE_XM_RDATA), .ONCHIP_WE(ONCHIP_WE),
    .ONCHIP_ADDR(ONCHIP_ADDR), .ONCHIP_WDATA(ONCHIP_WDATA), .XM_WE(XM_WE), .XM_RE(XM_RE),
    .XM_ADDR(XM_ADDR), .XM_WDATA(XM_WDATA), .XM_RDATA(XM_RDATA), .SEQ_ACTIVE(SEQ_ACTIVE));
  far_side u_far (.CLK(CLK), .XM_WE(XM_WE), .XM_RE(XM_RE), .XM_ADDR(XM_ADDR),
    .XM_WDATA(XM_WDATA), .XM_RDATA(XM_RDATA), .CONV_A_DONE(CONV_A_DONE),
    .CONV_B_DONE(CONV_B_DONE), .CONV_A_RESULT(CONV_A_RESULT), .CONV_B_RESULT(CONV_B_RESULT));

  always #12.5 CLK = ~CLK;

  // Log writes at the edge that samples them
  always @(posedge CLK) begin
    if (ONCHIP_WE === 1'b1) wq.push_back({ONCHIP_ADDR, ONCHIP_WDATA});
    if (XM_WE === 1'b1) xq.push_back({XM_ADDR, XM_WDATA});
    if (XM_RE === 1'b1) n_re++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until PREADY is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // Deliver results, optionally with the core holding on-chip memory
  task automatic feed(input logic a, input logic b, input logic [15:0] v, input logic blk);
    int n0;
    n0 = wq.size();
    CORE_ONCHIP_BUSY <= blk;
    u_far.convert(a, b, v);
    if (blk) begin
      repeat (10) @(posedge CLK);
      chk(32'(wq.size()), 32'(n0));
      CORE_ONCHIP_BUSY <= 1'b0;
    end
    while (wq.size() < n0 + a + b) begin
      @(posedge CLK);
    end
    repeat (4) @(posedge CLK);
  endtask

  // Core off-chip access; read data sampled two edges after the request
  task automatic core(input logic w, input logic [15:0] a, input logic [15:0] d);
    CORE_XM_REQ <= 1'b1;
    CORE_XM_WE <= w;
    CORE_XM_ADDR <= a;
    CORE_XM_WDATA <= d;
    @(posedge CLK);
    CORE_XM_REQ <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    num_errors++;
    end_sim;
  end

  initial begin
    logic [15:0] v, da;
    int e;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rc(`OFS_CTRL, 32'h0);
    rc(`OFS_CONFIG, 32'h0);
    wr(`OFS_INSTR_PTR, 32'd63);
    wr(`OFS_INSTR_DATA, 32'h20);
    rc(`OFS_INSTR_PTR, 32'h0);
    wr(`OFS_INSTR_PTR, 32'd63);
    rc(`OFS_INSTR_DATA, 32'h20);
    rc(`OFS_INSTR_PTR, 32'h0);
    rc(12'h028, 32'h0);
    chk(perr, 1'b1);
    // Junk ahead of the start boundary, then the program
    wr(`OFS_INSTR_PTR, 32'h0);
    wr(`OFS_INSTR_DATA, 32'h30);
    wr(`OFS_INSTR_DATA, 32'h30);
    for (int i = 0; i < 6; i++) wr(`OFS_INSTR_DATA, prog[i]);
    wr(`OFS_START_BND, 32'h2);
    wr(`OFS_DEST_START, 32'h0100);
    wr(`OFS_REP_LIMIT, 32'h2);
    wr(`OFS_CTRL, 32'h80);
    rc(`OFS_REP_COUNT, 32'h2);
    rc(`OFS_DEST_PTR, 32'h0100);
    rc(`OFS_CUR_INSTR, 32'h2);
    da = 16'h0100;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        v = 16'h0A00 + 16'(p * 8 + i);
        if (prog[i][4] | prog[i][6]) ea.push_back({da, v});
        if (prog[i][4] | prog[i][6]) da = da + 16'h2;
        if (prog[i][5]) ea.push_back({da, ~v});
        if (prog[i][5]) da = da + 16'h2;
        feed(prog[i][4] | prog[i][6], prog[i][5], v, p == 0 && i == 2);
      end
    end
    repeat (10) @(posedge CLK);
    chk(SEQ_ACTIVE, 1'b0);
    chk(32'(wq.size()), 32'd14);
    foreach (ea[k]) chk(wq[k], ea[k]);
    rc(`OFS_DEST_PTR, 32'h011C);
    rc(`OFS_CUR_INSTR, 32'h2);
    rc(`OFS_CTRL, 32'h40);
    wr(`OFS_CTRL, 32'h0);
    rc(`OFS_CTRL, 32'h0);
    // Continuous run, then overflow while the core blocks memory
    wr(`OFS_INSTR_PTR, 32'h2);
    wr(`OFS_INSTR_DATA, 32'h90);
    wr(`OFS_INSTR_DATA, 32'h80);
    wr(`OFS_DEST_START, 32'h0200);
    wr(`OFS_REP_LIMIT, 32'h1);
    wr(`OFS_CTRL, 32'h80);
    for (int i = 0; i < 3; i++) feed(1'b1, 1'b0, 16'(16'h0B00 + i), 1'b0);
    chk(SEQ_ACTIVE, 1'b1);
    chk(wq[14], {16'h0200, 16'h0B00});
    CORE_ONCHIP_BUSY <= 1'b1;
    repeat (3) u_far.convert(1'b1, 1'b0, 16'h0C00);
    rc(`OFS_CTRL, 32'h89);
    CORE_ONCHIP_BUSY <= 1'b0;
    repeat (10) @(posedge CLK);
    wr(`OFS_CTRL, 32'h0);
    // Off-chip ownership by the hold bit
    rc(`OFS_CONFIG, 32'h0);
    wr(`OFS_CONFIG, 32'h10);
    core(1'b1, 16'h0004, 16'h1234);
    core(1'b0, 16'h0004, 16'h0);
    chk(CORE_XM_RDATA, 16'h1234);
    wr(`OFS_DEST_START, 32'h1000);
    wr(`OFS_CTRL, 32'h80);
    u_far.convert(1'b1, 1'b0, 16'h0D0D);
    repeat (10) @(posedge CLK);
    chk(32'(xq.size()), 32'd1);
    wr(`OFS_CONFIG, 32'h0);
    repeat (10) @(posedge CLK);
    chk(xq[0], {16'h0004, 16'h1234});
    chk(xq[1], {16'h1000, 16'h0D0D});
    e = n_re;
    core(1'b0, 16'h0004, 16'h0);
    chk(CORE_XM_RDATA, 16'h0);
    chk(32'(n_re), 32'(e));
    core(1'b1, 16'h0006, 16'hBEEF);
    chk(32'(xq.size()), 32'd2);
    wr(`OFS_CTRL, 32'h0);
    end_sim;
  end
endmodule
